/* src/vbr_defines.svh */
/*
 * Constants of the regulator control and bus power detect block:
 * register byte offsets, bit positions, reset values, timing counts.
 * Assumes a 20 MHz system clock and a classic Wishbone register bus.
 */
`ifndef VBR_DEFINES_SVH
`define VBR_DEFINES_SVH

// register byte offsets
`define VBR_ADR_CTL       8'h00
`define VBR_ADR_CFG       8'h04
`define VBR_ADR_STAT      8'h08
`define VBR_ADR_CLR       8'h0C
`define VBR_ADR_EN        8'h10

// regulator control register fields
`define VBR_CTL_DIS       7
`define VBR_CTL_VBST      6
`define VBR_CTL_LP        4
`define VBR_CTL_STOP      3
`define VBR_CTL_CORE_LP   1
`define VBR_CTL_MPC       0
`define VBR_CTL_RST       8'h00
`define VBR_CTL_WMASK     8'hBF

// bus power configuration fields
`define VBR_CFG_IRQEN     0
`define VBR_CFG_RSTEN     1
`define VBR_CFG_RST       2'h0

// sticky event fields
`define VBR_STAT_RST      0
`define VBR_STAT_MISUSE   1
`define VBR_STAT_RST_VAL  2'h0
`define VBR_EN_RST_VAL    2'h0

// synchroniser priming
`define VBR_PRIME_DONE    2'h3

// timing
`define VBR_CLK_NS        50
`define VBR_RST_NS        800
`define VBR_RST_CYC       ((`VBR_RST_NS + `VBR_CLK_NS - 1) / `VBR_CLK_NS)

`endif

/* src/vbr_pkg.sv */
/*
 * Types of the regulator control and bus power detect block.
 * Assumes the constants header for field positions.
 */
package vbr_pkg;

  // wishbone request from the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } vbr_wb_req_t;

  // wishbone answer to the master
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } vbr_wb_rsp_t;

  // synchroniser state
  typedef struct packed {
    logic s1;
    logic s2;
  } vbr_sync_t;

  // block state
  typedef struct packed {
    logic [7:0]  ctl;
    logic [1:0]  cfg;
    logic [1:0]  stat;
    logic [1:0]  en;
    logic        ack;
    logic [31:0] rdat;
    logic        prev;
    logic [1:0]  prime;
    logic        irq_pulse;
    logic [4:0]  rst_cnt;
  } vbr_state_t;

endpackage : vbr_pkg

/* src/vbr_sync.sv */
/*
 * Two-stage synchroniser for the bus power input.
 * Assumes an asynchronous input and one system clock.
 */
`timescale 1ns/1ps
module vbr_sync
  import vbr_pkg::*;
(
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic nrst,
  // level in and out
  input  wire logic din,
  output logic      dout
);

  vbr_sync_t s_reg;
  vbr_sync_t s_next;

  // first stage feeds only the second
  always_comb begin
    s_next    = s_reg;
    s_next.s1 = din;
    s_next.s2 = s_reg.s1;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign dout = s_reg.s2;

endmodule : vbr_sync

/* src/vbr_top.sv */
/*
 * Regulator control and bus power detect logic with a Wishbone slave.
 * Assumes a classic Wishbone master on clk_sys and an asynchronous
 * bus power input; system reset logic consumes sys_reset_req.
 */
// Notes on behaviour
// - software turns the main regulator on or off through the disable bit.
// - the low power select bit chooses normal or suspend mode of the main regulator.
// - the bus power status bit follows the present input level, never latched.
// - with its enable set, every rising and falling input edge raises an interrupt.
// - the bus power interrupt is a pulse per edge with no pending flag to read.
// - with bus power chosen as reset source, every edge requests a system reset.
// - the core regulator has two power saving settings in the control register.
// - the disable bit means enabled at zero, disabled at one, and resets to zero.
// - the status bit reads one when bus power is present and zero when absent.
// - the low power select bit means low power at one and normal at zero.
`timescale 1ns/1ps
`include "vbr_defines.svh"
module vbr_top
  import vbr_pkg::*;
(
  // clock and reset
  input  wire logic  clk_sys,
  input  wire logic  nrst,
  // register bus
  input  vbr_wb_req_t wb_req,
  output vbr_wb_rsp_t wb_rsp,
  // bus power input
  input  wire logic  vbus_in,
  // regulator controls
  output logic       main_regulator_disable,
  output logic       main_regulator_low_power_select,
  output logic       core_regulator_low_power_select,
  output logic       core_regulator_stop_shutdown,
  output logic       mem_power_ctl_enable,
  // status and events
  output logic       bus_power_level_status,
  output logic       bus_power_irq,
  output logic       sys_reset_req,
  output logic       irq
);

  // address match
  function automatic logic vbr_hit(input logic [7:0] adr, input logic [7:0] off);
    vbr_hit = (adr == off);
  endfunction : vbr_hit

  vbr_state_t s_reg;
  vbr_state_t s_next;

  logic       vbus_sync;
  logic       bus_req;
  logic       wr_fire;
  logic       rd_load;
  logic       wr_ctl;
  logic       wr_cfg;
  logic       wr_clr;
  logic       wr_en;
  logic       primed;
  logic       edge_det;
  logic [1:0] evt;
  logic [7:0] ctl_view;
  logic [7:0] ctl_new;

  vbr_sync u_sync (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .din     (vbus_in),
    .dout    (vbus_sync)
  );

  // bus decode
  assign bus_req = wb_req.cyc && wb_req.stb;
  assign rd_load = bus_req && !s_reg.ack;
  assign wr_fire = bus_req && s_reg.ack && wb_req.we && wb_req.sel[0];
  assign wr_ctl  = wr_fire && vbr_hit(wb_req.adr, `VBR_ADR_CTL);
  assign wr_cfg  = wr_fire && vbr_hit(wb_req.adr, `VBR_ADR_CFG);
  assign wr_clr  = wr_fire && vbr_hit(wb_req.adr, `VBR_ADR_CLR);
  assign wr_en   = wr_fire && vbr_hit(wb_req.adr, `VBR_ADR_EN);

  // edges only after both stages are filled
  assign primed   = (s_reg.prime == `VBR_PRIME_DONE);
  assign edge_det = primed && (vbus_sync != s_reg.prev);

  // live level in the status position
  always_comb begin
    ctl_view                = s_reg.ctl;
    ctl_view[`VBR_CTL_VBST] = vbus_sync;
  end

  // new control value on a write
  assign ctl_new = wb_req.dat[7:0] & `VBR_CTL_WMASK;

  // sticky events
  always_comb begin
    evt = 2'h0;
    evt[`VBR_STAT_RST] = edge_det && s_reg.cfg[`VBR_CFG_RSTEN];
    // core low power with main regulator off
    evt[`VBR_STAT_MISUSE] = wr_ctl && ctl_new[`VBR_CTL_CORE_LP]
                            && ctl_new[`VBR_CTL_DIS];
  end

  always_comb begin
    s_next = s_reg;

    // single-cycle answer
    s_next.ack = rd_load;
    if (rd_load) begin
      s_next.rdat = 32'h0000_0000;
      if (vbr_hit(wb_req.adr, `VBR_ADR_CTL)) begin
        s_next.rdat[7:0] = ctl_view;
      end
      if (vbr_hit(wb_req.adr, `VBR_ADR_CFG)) begin
        s_next.rdat[1:0] = s_reg.cfg;
      end
      if (vbr_hit(wb_req.adr, `VBR_ADR_STAT)) begin
        s_next.rdat[1:0] = s_reg.stat;
      end
      if (vbr_hit(wb_req.adr, `VBR_ADR_EN)) begin
        s_next.rdat[1:0] = s_reg.en;
      end
    end

    if (wr_ctl) begin
      s_next.ctl = ctl_new;
    end
    if (wr_cfg) begin
      s_next.cfg = wb_req.dat[1:0];
    end
    if (wr_en) begin
      s_next.en = wb_req.dat[1:0];
    end

    // set wins over clear
    if (wr_clr) begin
      s_next.stat = (s_reg.stat & ~wb_req.dat[1:0]) | evt;
    end else begin
      s_next.stat = s_reg.stat | evt;
    end

    s_next.prev = vbus_sync;
    if (!primed) begin
      s_next.prime = s_reg.prime + 2'h1;
    end

    s_next.irq_pulse = edge_det && s_reg.cfg[`VBR_CFG_IRQEN];

    if (edge_det && s_reg.cfg[`VBR_CFG_RSTEN]) begin
      s_next.rst_cnt = 5'(`VBR_RST_CYC);
    end else if (s_reg.rst_cnt != 5'h00) begin
      s_next.rst_cnt = s_reg.rst_cnt - 5'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_reg           <= '0;
      s_reg.ctl       <= `VBR_CTL_RST;
      s_reg.cfg       <= `VBR_CFG_RST;
      s_reg.stat      <= `VBR_STAT_RST_VAL;
      s_reg.en        <= `VBR_EN_RST_VAL;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs
  assign wb_rsp = '{ack: s_reg.ack, dat: s_reg.rdat};

  assign main_regulator_disable          = s_reg.ctl[`VBR_CTL_DIS];
  assign main_regulator_low_power_select = s_reg.ctl[`VBR_CTL_LP];
  assign core_regulator_low_power_select = s_reg.ctl[`VBR_CTL_CORE_LP];
  assign core_regulator_stop_shutdown    = s_reg.ctl[`VBR_CTL_STOP];
  assign mem_power_ctl_enable            = s_reg.ctl[`VBR_CTL_MPC];

  assign bus_power_level_status = vbus_sync;
  assign bus_power_irq = s_reg.irq_pulse;
  assign sys_reset_req = (s_reg.rst_cnt != 5'h00);
  assign irq           = |(s_reg.stat & s_reg.en);

  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  property p_dis_write;
    wr_ctl |=> main_regulator_disable == $past(wb_req.dat[7]);
  endproperty
  a_dis_write: assert property (p_dis_write)
    else $error("main regulator disable did not follow write");

  property p_lp_write;
    wr_ctl |=> main_regulator_low_power_select == $past(wb_req.dat[4]);
  endproperty
  a_lp_write: assert property (p_lp_write)
    else $error("low power select did not follow write");

  property p_status_live;
    primed |-> bus_power_level_status == $past(vbus_in, 2);
  endproperty
  a_status_live: assert property (p_status_live)
    else $error("bus power status does not track input");

  property p_irq_edge;
    (edge_det && s_reg.cfg[0]) |=> bus_power_irq;
  endproperty
  a_irq_edge: assert property (p_irq_edge)
    else $error("bus power edge gave no interrupt");

  property p_irq_cause;
    bus_power_irq |-> $past(edge_det) && $past(s_reg.cfg[0]);
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("bus power interrupt without edge");

  property p_rst_edge;
    (edge_det && s_reg.cfg[1]) |=> sys_reset_req [*8];
  endproperty
  a_rst_edge: assert property (p_rst_edge)
    else $error("reset request missing or too short");

  property p_rst_cause;
    $rose(sys_reset_req) |-> $past(edge_det) && $past(s_reg.cfg[1]);
  endproperty
  a_rst_cause: assert property (p_rst_cause)
    else $error("reset request without edge");

  property p_core_write;
    wr_ctl |=> core_regulator_low_power_select == $past(wb_req.dat[1])
               && core_regulator_stop_shutdown == $past(wb_req.dat[3]);
  endproperty
  a_core_write: assert property (p_core_write)
    else $error("core regulator settings did not follow write");

  property p_dis_stable;
    !wr_ctl |=> $stable(main_regulator_disable);
  endproperty
  a_dis_stable: assert property (p_dis_stable)
    else $error("disable changed without a write");

  property p_read_status;
    (rd_load && wb_req.adr == 8'h00) |=> wb_rsp.dat[6] == $past(vbus_sync);
  endproperty
  a_read_status: assert property (p_read_status)
    else $error("status bit read back wrong");

  property p_lp_stable;
    !wr_ctl |=> $stable(main_regulator_low_power_select);
  endproperty
  a_lp_stable: assert property (p_lp_stable)
    else $error("low power select changed without a write");

  property p_edge_sync;
    edge_det |-> $past(vbus_in, 2) != $past(vbus_in, 3);
  endproperty
  a_edge_sync: assert property (p_edge_sync)
    else $error("edge without a synchronised input change");

  property p_set_wins;
    (evt[0] && wr_clr && wb_req.dat[0]) |=> s_reg.stat[0];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("event lost against clear");

  property p_ack_once;
    wb_rsp.ack |=> !wb_rsp.ack;
  endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("ack held longer than one cycle");

  property p_ack_answer;
    (bus_req && !wb_rsp.ack) |=> wb_rsp.ack;
  endproperty
  a_ack_answer: assert property (p_ack_answer)
    else $error("request not answered in one cycle");

  property p_ack_cause;
    wb_rsp.ack |-> $past(bus_req);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without a request");

  property p_rd_upper;
    wb_rsp.ack |-> wb_rsp.dat[31:8] == 24'h00_0000;
  endproperty
  a_rd_upper: assert property (p_rd_upper)
    else $error("read data upper bits not zero");

  property p_stat_hold;
    (s_reg.stat[`VBR_STAT_RST] && !wr_clr) |=> s_reg.stat[`VBR_STAT_RST];
  endproperty
  a_stat_hold: assert property (p_stat_hold)
    else $error("reset request flag lost without a clear");

  property p_clr_works;
    (wr_clr && wb_req.dat[0] && !evt[0]) |=> !s_reg.stat[0];
  endproperty
  a_clr_works: assert property (p_clr_works)
    else $error("reset request flag not cleared");

  property p_misuse_set;
    (wr_ctl && wb_req.dat[1] && wb_req.dat[7]) |=> s_reg.stat[1];
  endproperty
  a_misuse_set: assert property (p_misuse_set)
    else $error("core low power with main off not flagged");

  property p_irq_quiet;
    !(edge_det && s_reg.cfg[0]) |=> !bus_power_irq;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet)
    else $error("bus power interrupt outside an enabled edge");

  property p_rst_quiet;
    (!sys_reset_req && !(edge_det && s_reg.cfg[1])) |=> !sys_reset_req;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("reset request raised without an edge");

  property p_cfg_write;
    wr_cfg |=> s_reg.cfg == $past(wb_req.dat[1:0]);
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("configuration did not follow write");

  property p_mpc_write;
    wr_ctl |=> mem_power_ctl_enable == $past(wb_req.dat[0]);
  endproperty
  a_mpc_write: assert property (p_mpc_write)
    else $error("memory power control did not follow write");

  property p_ctl_ro_bit;
    wr_ctl |=> !s_reg.ctl[`VBR_CTL_VBST];
  endproperty
  a_ctl_ro_bit: assert property (p_ctl_ro_bit)
    else $error("status position stored by a write");

endmodule : vbr_top

/* test/vbr_vbus_model.sv */
/*
 * bus power supply line model: drives the level seen by the block.
 * assumes the bench calls drive() from its own process.
 */
`timescale 1ns/1ps
module vbr_vbus_model (
  // clock
  input  wire logic clk_sys,
  // supply level
  output logic      vbus_in
);
  initial vbus_in = 1'b0;

  task automatic drive(input logic lvl, input int hold);
    @(posedge clk_sys);
    vbus_in <= lvl;
    repeat (hold) @(posedge clk_sys);
  endtask : drive
endmodule : vbr_vbus_model

/* test/vbr_top_tb.sv */
/*
 * self-checking bench of the regulator control and bus power block.
 * assumes the design files and the constants header on the include path.
 */
`timescale 1ns/1ps
`include "vbr_defines.svh"
module vbr_top_tb
  import vbr_pkg::*;
;
  logic        clk_sys;
  logic        nrst;
  vbr_wb_req_t wb_req;
  vbr_wb_rsp_t wb_rsp;
  logic        vbus_in;
  logic        mdis;
  logic        mlp;
  logic        clp;
  logic        cstop;
  logic        mpc;
  logic        stat_lvl;
  logic        bp_irq;
  logic        rst_req;
  logic        irq;
  int          failures;
  int          tests_run;
  int          irq_cnt;
  int          rst_cnt;
  logic [31:0] q;

  vbr_top dut_u (
    .clk_sys(clk_sys), .nrst(nrst), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .vbus_in(vbus_in), .main_regulator_disable(mdis),
    .main_regulator_low_power_select(mlp), .core_regulator_low_power_select(clp),
    .core_regulator_stop_shutdown(cstop), .mem_power_ctl_enable(mpc),
    .bus_power_level_status(stat_lvl), .bus_power_irq(bp_irq),
    .sys_reset_req(rst_req), .irq(irq)
  );
  vbr_vbus_model vbus_u (.clk_sys(clk_sys), .vbus_in(vbus_in));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // event counters
  always @(posedge clk_sys) begin
    if (bp_irq === 1'b1) irq_cnt++;
    if (rst_req === 1'b1) rst_cnt++;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
    do begin
      @(posedge clk_sys);
    end while (wb_rsp.ack !== 1'b1);
    q = wb_rsp.dat;
    wb_req <= '0;
  endtask : bus

  task automatic t_ctl();
    bus(1'b0, `VBR_ADR_CTL, 32'h0);
    check(q, 32'h0);
    bus(1'b1, `VBR_ADR_CTL, 32'hFF);
    bus(1'b0, `VBR_ADR_STAT, 32'h0);
    check(q, 32'h2);
    bus(1'b0, `VBR_ADR_CTL, 32'h0);
    check(q, 32'hBF);
    check({mdis, mlp, clp, cstop, mpc}, 5'h1F);
    bus(1'b1, `VBR_ADR_CTL, 32'h0);
    @(posedge clk_sys);
    check({mdis, mlp, clp, cstop, mpc}, 5'h00);
    $display("test ctl done");
  endtask : t_ctl

  task automatic t_edges();
    bus(1'b1, `VBR_ADR_CFG, 32'h1);
    irq_cnt = 0;
    rst_cnt = 0;
    vbus_u.drive(1'b1, 8);
    check(irq_cnt, 1);
    check(stat_lvl, 1'b1);
    bus(1'b0, `VBR_ADR_CTL, 32'h0);
    check(q, 32'h40);
    vbus_u.drive(1'b0, 8);
    check(irq_cnt, 2);
    check(rst_cnt, 0);
    check(stat_lvl, 1'b0);
    $display("test edges done");
  endtask : t_edges

  task automatic t_rst_src();
    bus(1'b1, `VBR_ADR_CLR, 32'h3);
    bus(1'b1, `VBR_ADR_CFG, 32'h2);
    bus(1'b1, `VBR_ADR_EN, 32'h1);
    irq_cnt = 0;
    rst_cnt = 0;
    vbus_u.drive(1'b1, 24);
    check(rst_cnt, `VBR_RST_CYC);
    check(irq_cnt, 0);
    check(irq, 1'b1);
    bus(1'b0, `VBR_ADR_STAT, 32'h0);
    check(q, 32'h1);
    bus(1'b1, `VBR_ADR_CLR, 32'h1);
    bus(1'b0, `VBR_ADR_STAT, 32'h0);
    check(q, 32'h0);
    check(irq, 1'b0);
    vbus_u.drive(1'b0, 24);
    check(rst_cnt, 2 * `VBR_RST_CYC);
    $display("test reset source done");
  endtask : t_rst_src

  task automatic t_map();
    bus(1'b1, 8'h14, 32'hFF);
    bus(1'b0, 8'h14, 32'h0);
    check(q, 32'h0);
    bus(1'b0, `VBR_ADR_CTL, 32'h0);
    check(q, 32'h0);
    $display("test map done");
  endtask : t_map

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run

  initial begin
    #(50 * 4000);
    failures++;
    complete_run();
  end

  initial begin
    failures = 0;
    tests_run = 0;
    irq_cnt = 0;
    rst_cnt = 0;
    wb_req = '0;
    nrst = 1'b0;
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    check({mdis, mlp, stat_lvl, bp_irq, rst_req, irq}, 6'h00);
    t_ctl();
    t_edges();
    t_rst_src();
    t_map();
    complete_run();
  end
endmodule : vbr_top_tb
